// ===== hw/bcw_cfg.svh
// Purpose: offsets, field positions, reset values and codes of the block
// Assumes: 32-bit apb data, one register per aligned word
// Notes: definitions only
`ifndef BCW_CFG_SVH
`define BCW_CFG_SVH
`define BCW_ADDR_W 12
`define BCW_OFF_CFG 12'h000
`define BCW_OFF_MSG_PTR 12'h004
`define BCW_OFF_CTRL 12'h008
`define BCW_OFF_INT_STAT 12'h00c
`define BCW_OFF_INT_MASK 12'h010
`define BCW_OFF_LAST_STAT 12'h014
`define BCW_RAM_PAGE 4'h1
`define BCW_RAM_AW 6
`define BCW_RST_CFG 2'h0
`define BCW_RST_MASK 2'h0
`define BCW_RST_PTR 6'h00
`define BCW_CFG_TSYNC_BIT 3
`define BCW_CFG_EVEN_BIT 2
`define BCW_CTRL_START_BIT 0
`define BCW_INT_DONE_BIT 0
`define BCW_INT_SSET_BIT 1
`define BCW_CW_TXTIME_BIT 15
`define BCW_CW_ME_MASK_BIT 14
`define BCW_CW_SR_MASK_BIT 13
`define BCW_CW_BSY_MASK_BIT 12
`define BCW_ST_ME_BIT 10
`define BCW_ST_SR_BIT 8
`define BCW_ST_BSY_BIT 3
`define BCW_CMD_TR_BIT 10
`define BCW_MODE_SYNC_DATA 5'h11
`define BCW_SA_MODE_LO 5'h00
`define BCW_SA_MODE_HI 5'h1f
`define BCW_BLK_CMD 6'h01
`define BCW_BLK_DPTR 6'h02
`define BCW_BLK_STAT 6'h07
`endif

// ===== hw/bcw_pkg.sv
// Purpose: shared types of the message control word logic
// Assumes: constants live in bcw_cfg.svh
// Notes: none
package bcw_pkg;
  typedef logic [15:0] bcw_word_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_CW, ST_RD_CMD, ST_RD_DP, ST_RD_DATA,
    ST_TX_CMD, ST_TX_DATA, ST_WAIT_STAT, ST_FINISH
  } bcw_state_e;
endpackage

// ===== hw/bcw_sync_sel.sv
// Purpose: picks the data word for a synchronize-with-data mode command
// Assumes: inputs stable while the word is built
// Notes: combinational
`timescale 1ns/1ps
`include "bcw_cfg.svh"
module bcw_sync_sel
  import bcw_pkg::*;
(
  input wire bcw_word_t i_ram_word,
  input wire bcw_word_t i_time_low,
  input wire logic i_send_time_opt,
  input wire logic i_time_sync_enable,
  input wire logic i_even_time_sync,
  output bcw_word_t o_word
);
  bcw_word_t t;
  always_comb
  begin
    t = i_time_low;
    if (i_even_time_sync)
    begin
      t[0] = 1'b0;
    end
    if (i_send_time_opt && i_time_sync_enable)
    begin
      o_word = t;
    end
    else
    begin
      o_word = i_ram_word;
    end
  end
endmodule // bcw_sync_sel

// ===== hw/bcw_status_eval.sv
// Purpose: decides the status-set condition from the rt status word
// Assumes: control word and command word held for the message
// Notes: combinational
`timescale 1ns/1ps
`include "bcw_cfg.svh"
module bcw_status_eval
  import bcw_pkg::*;
(
  input wire bcw_word_t i_status,
  input wire bcw_word_t i_cmd,
  input wire bcw_word_t i_ctrl_word,
  output logic o_status_set
);
  logic me_hit;
  logic sr_hit;
  logic bsy_hit;
  logic addr_bad;
  always_comb
  begin
    me_hit = i_status[`BCW_ST_ME_BIT] &
      !i_ctrl_word[`BCW_CW_ME_MASK_BIT];
    sr_hit = i_status[`BCW_ST_SR_BIT] &
      !i_ctrl_word[`BCW_CW_SR_MASK_BIT];
    bsy_hit = i_status[`BCW_ST_BSY_BIT] &
      !i_ctrl_word[`BCW_CW_BSY_MASK_BIT];
    addr_bad = i_status[15:11] != i_cmd[15:11];
    o_status_set = me_hit | sr_hit | bsy_hit | addr_bad;
  end
endmodule // bcw_status_eval

// ===== hw/bcw_top.sv
// Purpose: bus controller per-message control word handling
// Assumes: host fills the message block in ram over apb before start
// Notes: words leave on a word port towards the serial encoder
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "bcw_cfg.svh"
module bcw_top
  import bcw_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [`BCW_ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_RX_STATUS_VALID,
  input wire bcw_pkg::bcw_word_t I_RX_STATUS,
  output bcw_pkg::bcw_word_t O_TX_WORD,
  output logic O_TX_VALID,
  output logic O_TX_IS_DATA,
  output logic O_STATUS_SET,
  output logic O_BUSY,
  output logic O_IRQ
);
  import bcw_pkg::*;

  bcw_state_e state_q;
  bcw_word_t mem [0:(1<<`BCW_RAM_AW)-1];
  logic [1:0] cfg_q;
  logic [`BCW_RAM_AW-1:0] ptr_q;
  logic [`BCW_RAM_AW-1:0] blk_q;
  logic [`BCW_RAM_AW-1:0] dp_q;
  logic [1:0] int_stat_q;
  logic [1:0] int_stat_d;
  logic [1:0] int_mask_q;
  bcw_word_t last_stat_q;
  bcw_word_t cw_q;
  bcw_word_t cmd_q;
  bcw_word_t sync_q;
  logic [31:0] time_q;
  logic [31:0] rdata;
  logic ready_q;
  logic acc;
  logic commit;
  logic is_ram;
  logic ok;
  logic mapped;
  logic start;
  logic is_sync;
  logic sset;
  logic ev_done;
  logic ev_sset;
  logic [`BCW_RAM_AW-1:0] ram_idx;
  bcw_word_t sync_word;

  // apb decode; ram is only open while no message runs
  assign acc = I_PSEL & I_PENABLE & !ready_q;
  assign commit = I_PSEL & I_PENABLE & ready_q;
  assign is_ram = I_PADDR[11:8] == `BCW_RAM_PAGE;
  assign ram_idx = I_PADDR[`BCW_RAM_AW+1:2];
  assign ok = !is_ram | (state_q == ST_IDLE);
  assign start = commit & I_PWRITE & (I_PADDR == `BCW_OFF_CTRL) &
    I_PWDATA[`BCW_CTRL_START_BIT] & (state_q == ST_IDLE);
  assign ev_done = state_q == ST_FINISH;
  assign ev_sset = (state_q == ST_WAIT_STAT) & I_RX_STATUS_VALID & sset;

  // only mode code 17 with data, sent bc to rt, is the sync command
  assign is_sync = (cmd_q[4:0] == `BCW_MODE_SYNC_DATA) &
    !cmd_q[`BCW_CMD_TR_BIT] &
    ((cmd_q[9:5] == `BCW_SA_MODE_LO) |
    (cmd_q[9:5] == `BCW_SA_MODE_HI));

  always_comb
  begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    if (is_ram)
    begin
      rdata = {16'h0000, mem[ram_idx]};
    end
    else
    begin
      case (I_PADDR)
        `BCW_OFF_CFG:
        begin
          rdata[`BCW_CFG_TSYNC_BIT] = cfg_q[1];
          rdata[`BCW_CFG_EVEN_BIT] = cfg_q[0];
        end
        `BCW_OFF_MSG_PTR: rdata[`BCW_RAM_AW-1:0] = ptr_q;
        `BCW_OFF_CTRL: rdata[0] = state_q != ST_IDLE;
        `BCW_OFF_INT_STAT: rdata[1:0] = int_stat_q;
        `BCW_OFF_INT_MASK: rdata[1:0] = int_mask_q;
        `BCW_OFF_LAST_STAT: rdata[15:0] = last_stat_q;
        default: mapped = 1'b0;
      endcase
    end
  end

  // answer one cycle into the access phase, held off while ram is busy
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      ready_q <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end
    else
    begin
      ready_q <= acc & ok;
      O_PRDATA <= (acc & ok & !I_PWRITE) ? rdata : 32'h0000_0000;
      O_PSLVERR <= acc & ok & !mapped;
    end
  end
  assign O_PREADY = ready_q;

  // software registers
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      cfg_q <= `BCW_RST_CFG;
      ptr_q <= `BCW_RST_PTR;
      int_mask_q <= `BCW_RST_MASK;
    end
    else if (commit & I_PWRITE)
    begin
      case (I_PADDR)
        `BCW_OFF_CFG: cfg_q <= {I_PWDATA[`BCW_CFG_TSYNC_BIT],
          I_PWDATA[`BCW_CFG_EVEN_BIT]};
        `BCW_OFF_MSG_PTR: ptr_q <= I_PWDATA[`BCW_RAM_AW-1:0];
        `BCW_OFF_INT_MASK: int_mask_q <= I_PWDATA[1:0];
        default: ;
      endcase
    end
  end

  // sticky events, cleared by a read; a new event beats the clear
  always_comb
  begin
    int_stat_d = int_stat_q;
    // clear only what the read reported, so an event landing between
    // the sample and the clear is kept
    if (commit & !I_PWRITE & (I_PADDR == `BCW_OFF_INT_STAT))
    begin
      int_stat_d = int_stat_q & ~O_PRDATA[1:0];
    end
    if (ev_done)
    begin
      int_stat_d[`BCW_INT_DONE_BIT] = 1'b1;
    end
    if (ev_sset)
    begin
      int_stat_d[`BCW_INT_SSET_BIT] = 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      int_stat_q <= 2'h0;
      O_IRQ <= 1'b0;
    end
    else
    begin
      int_stat_q <= int_stat_d;
      O_IRQ <= |(int_stat_d & int_mask_q);
    end
  end

  // free-running time base; only the low half is ever sent
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      time_q <= 32'h0000_0000;
    end
    else
    begin
      time_q <= time_q + 32'h0000_0001;
    end
  end

  bcw_sync_sel u_sync_sel (
    .i_ram_word(mem[dp_q]),
    .i_time_low(time_q[15:0]),
    .i_send_time_opt(cw_q[`BCW_CW_TXTIME_BIT]),
    .i_time_sync_enable(cfg_q[1]),
    .i_even_time_sync(cfg_q[0]),
    .o_word(sync_word)
  );

  bcw_status_eval u_status_eval (
    .i_status(I_RX_STATUS),
    .i_cmd(cmd_q),
    .i_ctrl_word(cw_q),
    .o_status_set(sset)
  );

  // message sequencer
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state_q <= ST_IDLE;
      blk_q <= `BCW_RST_PTR;
      dp_q <= `BCW_RST_PTR;
      cw_q <= 16'h0000;
      cmd_q <= 16'h0000;
      sync_q <= 16'h0000;
      last_stat_q <= 16'h0000;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            blk_q <= ptr_q;
            state_q <= ST_RD_CW;
          end
        end
        ST_RD_CW:
        begin
          cw_q <= mem[blk_q];
          state_q <= ST_RD_CMD;
        end
        ST_RD_CMD:
        begin
          cmd_q <= mem[blk_q + `BCW_BLK_CMD];
          state_q <= ST_RD_DP;
        end
        ST_RD_DP:
        begin
          dp_q <= mem[blk_q + `BCW_BLK_DPTR][`BCW_RAM_AW-1:0];
          state_q <= ST_RD_DATA;
        end
        ST_RD_DATA:
        begin
          sync_q <= sync_word;
          state_q <= ST_TX_CMD;
        end
        ST_TX_CMD:
        begin
          state_q <= is_sync ? ST_TX_DATA : ST_WAIT_STAT;
        end
        ST_TX_DATA:
        begin
          state_q <= ST_WAIT_STAT;
        end
        ST_WAIT_STAT:
        begin
          if (I_RX_STATUS_VALID)
          begin
            last_stat_q <= I_RX_STATUS;
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH:
        begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ram: host writes when idle, sequencer writes back sync word and status
  always_ff @(posedge I_SYS_CLK)
  begin
    if (commit & I_PWRITE & is_ram & (state_q == ST_IDLE))
    begin
      mem[ram_idx] <= I_PWDATA[15:0];
    end
    else if (state_q == ST_TX_DATA)
    begin
      mem[dp_q] <= sync_q;
    end
    else if ((state_q == ST_WAIT_STAT) & I_RX_STATUS_VALID)
    begin
      mem[blk_q + `BCW_BLK_STAT] <= I_RX_STATUS;
    end
  end

  // word port: command then optional sync data; control word never leaves
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_TX_WORD <= 16'h0000;
      O_TX_VALID <= 1'b0;
      O_TX_IS_DATA <= 1'b0;
    end
    else
    begin
      O_TX_VALID <= 1'b0;
      O_TX_IS_DATA <= 1'b0;
      if (state_q == ST_TX_CMD)
      begin
        O_TX_WORD <= cmd_q;
        O_TX_VALID <= 1'b1;
      end
      else if (state_q == ST_TX_DATA)
      begin
        O_TX_WORD <= sync_q;
        O_TX_VALID <= 1'b1;
        O_TX_IS_DATA <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_STATUS_SET <= 1'b0;
      O_BUSY <= 1'b0;
    end
    else
    begin
      O_STATUS_SET <= ev_sset;
      O_BUSY <= (state_q != ST_IDLE) | start;
    end
  end
endmodule // bcw_top

// ===== tb/bcw_top_asserts.sv
// Purpose: port checks of bcw_top
// Assumes: one clock domain
// Notes: bound from the bench top file
`timescale 1ns/1ps
module bcw_top_asserts
  import bcw_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_RX_STATUS_VALID,
  input wire bcw_pkg::bcw_word_t O_TX_WORD,
  input wire logic O_TX_VALID,
  input wire logic O_TX_IS_DATA,
  input wire logic O_STATUS_SET,
  input wire logic O_BUSY
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  sequence s_cmd;
    O_TX_VALID && !O_TX_IS_DATA;
  endsequence
  sequence s_data;
    O_TX_VALID && O_TX_IS_DATA;
  endsequence
  sequence s_sync_cmd;
    O_TX_VALID && !O_TX_IS_DATA && O_TX_WORD[4:0] == 5'h11 &&
      !O_TX_WORD[10] &&
      (O_TX_WORD[9:5] == 5'h00 || O_TX_WORD[9:5] == 5'h1f);
  endsequence
  a_rdy_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("pready held too long");
  a_rdy_cause: assert property (O_PREADY |-> $past(I_PSEL && I_PENABLE))
    else $error("pready without access");
  a_err_rdy: assert property (O_PSLVERR |-> O_PREADY)
    else $error("pslverr without pready");
  a_data_pair: assert property (s_data |-> $past(O_TX_VALID))
    else $error("data word not right after command");
  a_data_sync: assert property (s_cmd ##1 s_data |->
    $past(O_TX_WORD[4:0]) == 5'h11 && !$past(O_TX_WORD[10]) &&
    ($past(O_TX_WORD[9:5]) == 5'h00 || $past(O_TX_WORD[9:5]) == 5'h1f))
    else $error("data word after other command");
  a_sync_data: assert property (s_sync_cmd |=> s_data)
    else $error("sync command without its data word");
  a_tx_busy: assert property (O_TX_VALID |-> O_BUSY)
    else $error("word sent while idle");
  a_sset_cause: assert property (
    O_STATUS_SET |-> $past(I_RX_STATUS_VALID))
    else $error("status set without status word");
  a_sset_pulse: assert property (O_STATUS_SET |=> !O_STATUS_SET)
    else $error("status set longer than a pulse");
endmodule // bcw_top_asserts

// ===== tb/bcw_rt_model.sv
// Purpose: remote terminal answering with a status word
// Assumes: one pulse per word sent
// Notes: answer delay set by the bench
`timescale 1ns/1ps
module bcw_rt_model
  import bcw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tx_valid,
  input wire bcw_pkg::bcw_word_t i_status,
  input wire logic [3:0] i_dly,
  output logic o_valid,
  output bcw_pkg::bcw_word_t o_status
);
  logic [3:0] cnt_q;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_q <= 4'h0;
      o_valid <= 1'b0;
      o_status <= 16'h0000;
    end
    else
    begin
      // restart on each word so the answer follows the last one
      cnt_q <= i_tx_valid ? i_dly : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
      o_valid <= cnt_q == 4'h1 && !i_tx_valid;
      // line not held between answers: it toggles
      o_status <= cnt_q == 4'h1 ? i_status : ~o_status;
    end
  end
endmodule // bcw_rt_model

// ===== tb/test_bcw_top.sv
// Purpose: self-checking bench of bcw_top
// Assumes: message block at word 0, data at word 16
// Notes: time words checked against a bench copy of the time base
`timescale 1ns/1ps
`include "bcw_cfg.svh"
module test_bcw_top
  import bcw_pkg::*;
;
  logic I_SYS_CLK = 0, I_RST = 1, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0;
  logic [11:0] I_PADDR = 12'h000;
  logic [31:0] I_PWDATA = 32'h0, O_PRDATA, rd;
  logic O_PREADY, O_PSLVERR, I_RX_STATUS_VALID, O_TX_VALID, O_TX_IS_DATA;
  logic O_STATUS_SET, O_BUSY, O_IRQ, sset_q, err;
  bcw_word_t I_RX_STATUS, O_TX_WORD, st_q, cmd_got, dat_got;
  bcw_word_t tbt = 16'h0000, t_exp, exp_w;
  logic [3:0] dly = 4'h1;
  int fail_count = 0, check_count = 0, cyc = 0, n_dat = 0;
  bcw_word_t cw[7] = '{16'h8000, 16'h0000, 16'hc000, 16'h8000, 16'hb000,
    16'h0000, 16'h0000};
  bcw_word_t cm[7] = '{16'h2811, 16'h2811, 16'h2811, 16'h2811, 16'h2841,
    16'h2c11, 16'h2bf1};
  bcw_word_t st[7] = '{16'h2800, 16'h2c00, 16'h2c00, 16'h2900, 16'h2908,
    16'h3000, 16'h2808};
  logic [3:0] cf[7] = '{4'h0, 4'h8, 4'h8, 4'hc, 4'hc, 4'h0, 4'h0};
  // data kind: 0 none, 1 ram word, 2 time, 3 even time
  logic [1:0] kd[7] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h1};
  logic ex[7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  bcw_top u_bcw_top (.*);
  bcw_rt_model u_bcw_rt_model (.i_clk(I_SYS_CLK), .i_rst(I_RST),
    .i_tx_valid(O_TX_VALID), .i_status(st_q), .i_dly(dly),
    .o_valid(I_RX_STATUS_VALID), .o_status(I_RX_STATUS));
  always #25 I_SYS_CLK = ~I_SYS_CLK;
  task test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge I_SYS_CLK);
    I_PSEL <= 1'b1;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_SYS_CLK);
    I_PENABLE <= 1'b1;
    @(posedge I_SYS_CLK iff O_PREADY);
    rd = O_PRDATA;
    err = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask
  always @(posedge I_SYS_CLK)
  begin
    cyc <= cyc + 1;
    // free-running time base; the sync word samples it two cycles
    // before the command goes out
    tbt <= I_RST ? 16'h0000 : tbt + 16'h0001;
    if (O_TX_VALID && !O_TX_IS_DATA)
    begin
      cmd_got <= O_TX_WORD;
      t_exp <= tbt - 16'h0002;
    end
    if (O_TX_VALID && O_TX_IS_DATA)
    begin
      dat_got <= O_TX_WORD;
      n_dat <= n_dat + 1;
    end
    if (O_STATUS_SET)
      sset_q <= 1'b1;
    if (cyc == 4000)
    begin
      fail_count++;
      test_done();
    end
  end
  initial
  begin
    repeat (12) @(posedge I_SYS_CLK);
    I_RST <= 1'b0;
    apb(1'b0, `BCW_OFF_CFG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `BCW_OFF_INT_MASK, 32'h2);
    for (int i = 0; i < 7; i++)
    begin
      dly <= i % 2 ? 4'h1 : 4'h9;
      apb(1'b1, `BCW_OFF_CFG, {28'h0, cf[i]});
      apb(1'b1, 12'h100, {16'h0, cw[i]});
      apb(1'b1, 12'h104, {16'h0, cm[i]});
      apb(1'b1, 12'h108, 32'h10);
      apb(1'b1, 12'h140, 32'h1235);
      st_q <= st[i];
      n_dat = 0;
      sset_q = 1'b0;
      apb(1'b1, `BCW_OFF_CTRL, 32'h1);
      repeat (2) @(posedge I_SYS_CLK);
      @(posedge I_SYS_CLK iff !O_BUSY);
      chk({16'h0, cmd_got}, {16'h0, cm[i]});
      chk(32'(n_dat), {31'h0, kd[i] != 2'h0});
      if (kd[i] == 2'h1)
        chk({16'h0, dat_got}, 32'h1235);
      if (kd[i] == 2'h2)
        chk({16'h0, dat_got}, {16'h0, t_exp});
      if (kd[i] == 2'h3)
        chk({16'h0, dat_got}, {16'h0, t_exp[15:1], 1'b0});
      // without a data word the ram word stays as written
      exp_w = kd[i] == 2'h2 ? t_exp : kd[i] == 2'h3 ?
        {t_exp[15:1], 1'b0} : 16'h1235;
      apb(1'b0, 12'h140, 32'h0);
      chk(rd, {16'h0, exp_w});
      chk({31'h0, sset_q}, {31'h0, ex[i]});
      chk({31'h0, O_IRQ}, {31'h0, ex[i]});
      apb(1'b0, `BCW_OFF_INT_STAT, 32'h0);
      chk(rd, {30'h0, ex[i], 1'b1});
      apb(1'b0, `BCW_OFF_LAST_STAT, 32'h0);
      chk(rd, {16'h0, st[i]});
      chk({31'h0, O_IRQ}, 32'h0);
      $display("test %0d done", i);
    end
    // unmapped place answers with an error and reads zero
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test unmapped done");
    // reset in mid message: all goes quiet, registers back to reset
    st_q <= 16'h2800;
    dly <= 4'h9;
    apb(1'b1, `BCW_OFF_CTRL, 32'h1);
    repeat (3) @(posedge I_SYS_CLK);
    chk({31'h0, O_BUSY}, 32'h1);
    I_RST <= 1'b1;
    repeat (2) @(posedge I_SYS_CLK);
    I_RST <= 1'b0;
    @(posedge I_SYS_CLK);
    chk({31'h0, O_BUSY}, 32'h0);
    chk({31'h0, O_IRQ}, 32'h0);
    chk({31'h0, O_TX_VALID}, 32'h0);
    apb(1'b0, `BCW_OFF_CFG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `BCW_OFF_INT_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `BCW_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    test_done();
  end
endmodule // test_bcw_top
bind bcw_top bcw_top_asserts u_bcw_top_asserts (.*);
